// ===== hw/sps_defines.svh
/*
 * Constants of the serial port: register addresses, bit positions,
 * reset values and bit-rate divider counts.
 * Assumes that it is included by bare name wherever these are used.
 */
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

`define SPS_ADDR_CTRL 8'hf8
`define SPS_ADDR_DATA 8'hf7
`define SPS_CTRL_RESET 8'h04
`define SPS_DATA_RESET 8'h00

`define SPS_B_DONE 7
`define SPS_B_WRITE_COLLISION_FLAG 6
`define SPS_B_EN 5
`define SPS_B_MS 4
`define SPS_B_CLOCK_IDLE_POLARITY 3
`define SPS_B_CLOCK_PHASE_SELECT 2
`define SPS_B_RSH 1
`define SPS_B_RSL 0

`define SPS_LAST_BIT 3'h7
`define SPS_LAST_TOGGLE 5'h0f

// The MISO synchroniser delays a sample by four cycles, so a master half
// period under five cycles would read the previous bit; eight is fastest.
`define SPS_HALF_RATE0 7'h08
`define SPS_HALF_RATE1 7'h10
`define SPS_HALF_RATE2 7'h20
`define SPS_HALF_RATE3 7'h40

`endif

// ===== hw/sps_pkg.sv
/*
 * Types shared by the serial port modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sps_pkg;
    typedef enum logic {
        SPS_IDLE,
        SPS_RUN
    } sps_state_e;
    typedef logic [7:0] sps_byte_t;
endpackage

// ===== hw/sps_pins_if.sv
/*
 * Synchronised pin levels and serial clock edges passed from the pin
 * synchroniser to the port core.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/10ps
interface sps_pins_if;
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
    logic sclk_rise;
    logic sclk_fall;
    modport prod (output sclk, mosi, miso, ss_n, sclk_rise, sclk_fall);
    modport cons (input sclk, mosi, miso, ss_n, sclk_rise, sclk_fall);
endinterface

// ===== hw/sps_pin_sync.sv
/*
 * Three-stage synchroniser for the four port pins, with a stable level
 * that changes once stages two and three agree, and serial clock edges.
 * Assumes the pins are asynchronous to clk_sys_i.
 */
`timescale 1ns/10ps
module sps_pin_sync (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Raw pin levels: sclk, mosi, miso, ss_n
    input wire logic [3:0] pins_i,
    // Synchronised view
    sps_pins_if.prod sync
);
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] stab_q;
    logic rise_q;
    logic fall_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= 4'h9;
            s2_q <= 4'h9;
            s3_q <= 4'h9;
        end else begin
            s1_q <= pins_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A level only moves once the last two stages agree, which filters a
    // single metastable sample without adding a fourth stage.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stab_q <= 4'h9;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stab_q[i] <= s3_q[i];
                end
            end
            rise_q <= (s2_q[0] == s3_q[0]) && s3_q[0] && !stab_q[0];
            fall_q <= (s2_q[0] == s3_q[0]) && !s3_q[0] && stab_q[0];
        end
    end

    assign sync.sclk = stab_q[0];
    assign sync.mosi = stab_q[1];
    assign sync.miso = stab_q[2];
    assign sync.ss_n = stab_q[3];
    assign sync.sclk_rise = rise_q;
    assign sync.sclk_fall = fall_q;
endmodule

// ===== hw/sps_core.sv
/*
 * Byte-wide serial port, master or slave, with its control and data
 * registers on the core's special-function-register port.
 * Assumes single-cycle register strobes on clk_sys_i and an outside
 * pad mux that hands the pins to the two-wire unit when disabled.
 */
`timescale 1ns/10ps
`include "sps_defines.svh"

module sps_core (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // Serial pins
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i,
    // Pin ownership towards the two-wire unit
    output logic port_enable_o
);
    logic [1:0] rst_q;
    logic rst_n;
    sps_pins_if pins ();
    logic done_q, write_collision_flag_q, en_q, ms_q, clock_idle_polarity_q, clock_phase_select_q, rsh_q, rsl_q;
    sps_pkg::sps_byte_t sh_q, rx_q, rdata_q;
    logic in_q, out_q, sclk_q, phase_q;
    logic sclk_oe_q, mosi_oe_q, miso_oe_q;
    logic [2:0] cnt_q;
    logic [6:0] div_q, half;
    logic [4:0] tog_q;
    sps_pkg::sps_state_e state_q;
    logic wr_ctl, wr_dat, rd_ctl, rd_dat, busy, abort, slave_on;
    logic lead, trail, done_ev, tick, rx_bit, launch;

    function automatic logic [6:0] half_count(input logic [1:0] sel);
        case (sel)
            2'h0: half_count = `SPS_HALF_RATE0;
            2'h1: half_count = `SPS_HALF_RATE1;
            2'h2: half_count = `SPS_HALF_RATE2;
            default: half_count = `SPS_HALF_RATE3;
        endcase
    endfunction

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    sps_pin_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .pins_i({ss_n_i, miso_i, mosi_i, sclk_i}),
        .sync(pins.prod)
    );

    assign wr_ctl = sfr_wr_i && sfr_addr_i == `SPS_ADDR_CTRL;
    assign wr_dat = sfr_wr_i && sfr_addr_i == `SPS_ADDR_DATA;
    assign rd_ctl = sfr_rd_i && sfr_addr_i == `SPS_ADDR_CTRL;
    assign rd_dat = sfr_rd_i && sfr_addr_i == `SPS_ADDR_DATA;
    // Reconfiguring the role or enable mid-byte leaves a half-shifted
    // word, so it is thrown away rather than resumed.
    assign abort = wr_ctl && (sfr_wdata_i[`SPS_B_EN] != en_q ||
                              sfr_wdata_i[`SPS_B_MS] != ms_q);
    assign slave_on = en_q && !ms_q && !pins.ss_n;
    assign busy = ms_q ? state_q == sps_pkg::SPS_RUN : cnt_q != 3'h0;
    assign launch = wr_dat && !busy && en_q && ms_q;
    assign half = half_count({rsh_q, rsl_q});
    assign tick = state_q == sps_pkg::SPS_RUN && div_q == half - 7'h01;
    assign rx_bit = ms_q ? pins.miso : pins.mosi;

    // Leading edge leaves the idle level; trailing edge returns to it.
    always_comb begin
        if (ms_q) begin
            lead = tick && !phase_q;
            trail = tick && phase_q;
        end else begin
            lead = slave_on && (clock_idle_polarity_q ? pins.sclk_fall : pins.sclk_rise);
            trail = slave_on && (clock_idle_polarity_q ? pins.sclk_rise : pins.sclk_fall);
        end
    end
    assign done_ev = trail && cnt_q == `SPS_LAST_BIT;

    // Master clock generator.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sps_pkg::SPS_IDLE;
            div_q <= 7'h00;
            sclk_q <= 1'b0;
            phase_q <= 1'b0;
            tog_q <= 5'h00;
        end else begin
            case (state_q)
                sps_pkg::SPS_IDLE: begin
                    sclk_q <= clock_idle_polarity_q;
                    div_q <= 7'h00;
                    phase_q <= 1'b0;
                    tog_q <= 5'h00;
                    if (launch && !abort) begin
                        state_q <= sps_pkg::SPS_RUN;
                    end
                end
                sps_pkg::SPS_RUN: begin
                    div_q <= tick ? 7'h00 : div_q + 7'h01;
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                        phase_q <= ~phase_q;
                        tog_q <= tog_q + 5'h01;
                    end
                    if (abort || done_ev) begin
                        state_q <= sps_pkg::SPS_IDLE;
                        sclk_q <= clock_idle_polarity_q;
                    end
                end
                default: state_q <= sps_pkg::SPS_IDLE;
            endcase
        end
    end

    // Shifter: with phase one the leading edge drives and the trailing
    // edge samples; with phase zero the leading edge samples.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= `SPS_DATA_RESET;
            rx_q <= `SPS_DATA_RESET;
            in_q <= 1'b0;
            out_q <= 1'b0;
            cnt_q <= 3'h0;
        end else if (abort) begin
            cnt_q <= 3'h0;
        end else if (wr_dat && !busy) begin
            sh_q <= sfr_wdata_i;
            out_q <= sfr_wdata_i[7];
            cnt_q <= 3'h0;
        end else if (lead) begin
            if (clock_phase_select_q) begin
                out_q <= sh_q[7];
            end else begin
                in_q <= rx_bit;
            end
        end else if (trail) begin
            sh_q <= {sh_q[6:0], clock_phase_select_q ? rx_bit : in_q};
            if (!clock_phase_select_q) begin
                out_q <= sh_q[6];
            end
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `SPS_LAST_BIT) begin
                rx_q <= {sh_q[6:0], clock_phase_select_q ? rx_bit : in_q};
            end
        end else if (!ms_q && pins.ss_n) begin
            cnt_q <= 3'h0;
            out_q <= sh_q[7];
        end
    end

    // Pin direction follows role and enable.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_oe_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            sclk_oe_q <= en_q && ms_q;
            mosi_oe_q <= en_q && ms_q;
            miso_oe_q <= slave_on;
        end
    end

    // Control register; a hardware set wins over a software clear.
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            {done_q, write_collision_flag_q, en_q, ms_q, clock_idle_polarity_q, clock_phase_select_q, rsh_q, rsl_q} <=
                `SPS_CTRL_RESET;
            rdata_q <= 8'h00;
        end else begin
            if (wr_ctl) begin
                {en_q, ms_q, clock_idle_polarity_q, clock_phase_select_q, rsh_q, rsl_q} <=
                    sfr_wdata_i[5:0];
            end
            if (done_ev) begin
                done_q <= 1'b1;
            end else if (wr_ctl) begin
                done_q <= sfr_wdata_i[`SPS_B_DONE];
            end else if (rd_dat) begin
                done_q <= 1'b0;
            end
            if (wr_dat && busy) begin
                write_collision_flag_q <= 1'b1;
            end else if (wr_ctl) begin
                write_collision_flag_q <= sfr_wdata_i[`SPS_B_WRITE_COLLISION_FLAG];
            end
            if (rd_ctl) begin
                rdata_q <= {done_q, write_collision_flag_q, en_q, ms_q, clock_idle_polarity_q, clock_phase_select_q, rsh_q,
                            ms_q ? rsl_q : pins.ss_n};
            end else if (rd_dat) begin
                rdata_q <= rx_q;
            end
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign sclk_o = sclk_q;
    assign sclk_oe_o = sclk_oe_q;
    assign mosi_o = out_q;
    assign mosi_oe_o = mosi_oe_q;
    assign miso_o = out_q;
    assign miso_oe_o = miso_oe_q;
    assign port_enable_o = en_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    sequence s_launch;
        launch && !abort;
    endsequence
    sequence s_running;
        busy [*8];
    endsequence

    a_burst_hold: assert property (s_launch |=> s_running)
        else $error("Master burst ended too early.");
    a_burst_count: assert property (done_ev && ms_q |->
        tog_q == `SPS_LAST_TOGGLE)
        else $error("Master burst did not have eight clock periods.");
    a_sclk_dir: assert property (sclk_oe_o |-> $past(en_q && ms_q))
        else $error("Serial clock driven outside master role.");
    a_miso_dir: assert property (miso_oe_o && mosi_oe_o |-> 1'b0)
        else $error("Both data lines driven at once.");
    a_sclk_idle: assert property (ms_q &&
        state_q == sps_pkg::SPS_IDLE ##1 state_q == sps_pkg::SPS_IDLE |->
        sclk_o == $past(clock_idle_polarity_q))
        else $error("Master clock not at idle level.");
    a_write_collision_flag_set: assert property (wr_dat && busy |=> write_collision_flag_q)
        else $error("Collision flag not set.");
    a_done_set: assert property (done_ev |=> done_q)
        else $error("Done flag not set at byte end.");
    a_done_read: assert property (rd_dat && !done_ev && !wr_ctl |=>
        !done_q)
        else $error("Data read did not clear done flag.");
    a_slave_gate: assert property (!ms_q && pins.ss_n |=>
        cnt_q == 3'h0)
        else $error("Slave shifted while deselected.");
    a_ss_readback: assert property (rd_ctl && !ms_q |=>
        sfr_rdata_o[0] == $past(pins.ss_n))
        else $error("Slave select level not readable.");
    a_abort_clean: assert property (abort |=> cnt_q == 3'h0 &&
        state_q == sps_pkg::SPS_IDLE)
        else $error("Reconfiguration did not abort the byte.");
endmodule

// ===== tb/sps_partner.sv
/*
 * Far-side model: a slave answering the port's clock, or a master that
 * makes the clock and slave select.
 * Assumes the bench resolves the shared pins and sets the mode inputs.
 */
`timescale 1ns/10ps
module sps_partner (
    // Resolved pins
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    // Mode shared with the port
    input wire logic clock_idle_polarity_i,
    input wire logic clock_phase_select_i,
    input wire logic slv_on_i,
    // Levels driven by the model
    output logic sclk_o,
    output logic mosi_o,
    output logic miso_o,
    output logic ss_n_o
);
    sps_pkg::sps_byte_t stx, srx, mtx;
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        miso_o = 1'b0;
        ss_n_o = 1'b1;
    end
    // Slave side: sample on one edge, move the next bit on the other.
    always @(sclk_i) begin
        if (slv_on_i && ((sclk_i != clock_idle_polarity_i) ^ clock_phase_select_i)) begin
            srx = {srx[6:0], mosi_i};
        end else if (slv_on_i) begin
            if (!clock_phase_select_i) stx = {stx[6:0], ~stx[0]};
            miso_o = stx[7];
            if (clock_phase_select_i) stx = {stx[6:0], ~stx[0]};
        end
    end
    task automatic slv_load(input sps_pkg::sps_byte_t b);
        stx = b;
        miso_o = b[7];
    endtask
    // Master side; the clock stands still outside the frame.
    task automatic mst_xfer(input sps_pkg::sps_byte_t b, input logic sel,
                            output sps_pkg::sps_byte_t r);
        mtx = b;
        r = 8'h00;
        sclk_o = clock_idle_polarity_i;
        #62.5;
        ss_n_o = ~sel;
        mosi_o = b[7];
        #62.5;
        repeat (8) begin
            sclk_o = ~clock_idle_polarity_i;
            if (clock_phase_select_i) begin
                mosi_o = mtx[7];
                mtx = {mtx[6:0], 1'b0};
            end else r = {r[6:0], miso_i};
            #62.5;
            sclk_o = clock_idle_polarity_i;
            if (!clock_phase_select_i) begin
                mtx = {mtx[6:0], 1'b0};
                mosi_o = mtx[7];
            end else r = {r[6:0], miso_i};
            #62.5;
        end
        if (!clock_phase_select_i) ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask
endmodule

// ===== tb/spi_master_slave_port_bench.sv
/*
 * Self-checking bench of the serial port core against a far-side model.
 * Assumes the design, package and interface files are compiled first.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error %s expected %h seen %h", n, e, g); \
    end \
end
module spi_master_slave_port_bench;
    logic clk_sys_i, rst_n_i, sfr_wr_i, sfr_rd_i;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic port_enable_o, p_sclk, p_mosi, p_miso, p_ss_n;
    logic clock_idle_polarity, clock_phase_select, slv_on, sclk_q;
    integer mismatches, comparisons, tog, t0, t1, cyc;
    wire sclk_w = sclk_oe_o ? sclk_o : p_sclk;
    wire mosi_w = mosi_oe_o ? mosi_o : p_mosi;
    wire miso_w = miso_oe_o ? miso_o : p_miso;
    wire [2:0] oes = {sclk_oe_o, mosi_oe_o, miso_oe_o};
    sps_core i_sps_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .ss_n_i(p_ss_n), .port_enable_o(port_enable_o));
    sps_partner i_sps_partner (.sclk_i(sclk_w), .mosi_i(mosi_w),
        .miso_i(miso_w), .clock_idle_polarity_i(clock_idle_polarity), .clock_phase_select_i(clock_phase_select), .slv_on_i(slv_on),
        .sclk_o(p_sclk), .mosi_o(p_mosi), .miso_o(p_miso), .ss_n_o(p_ss_n));
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (sclk_o !== sclk_q) begin
            if (tog == 0) t0 = cyc;
            t1 = cyc;
            tog = tog + 1;
        end
        sclk_q = sclk_o;
    end
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge clk_sys_i);
        sfr_wr_i = 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clk_sys_i);
        sfr_rd_i = 1'b0;
        @(negedge clk_sys_i);
        d = sfr_rdata_o;
    endtask
    task automatic wait_done(output logic [7:0] c);
        integer n;
        n = 0;
        c = 8'h00;
        while (c[7] !== 1'b1 && n < 500) begin
            rdr(8'hf8, c);
            n = n + 1;
        end
        if (c[7] !== 1'b1) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    endtask
    task automatic t_reset();
        logic [7:0] c;
        // Select held low so the low rate bit reads the same in any view.
        i_sps_partner.ss_n_o = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        rdr(8'hf8, c);
        `CHK("ctrl reset", 8'h04, c)
        wr(8'hf9, 8'hff);
        rdr(8'hf8, c);
        `CHK("unmapped", 8'h04, c)
        rdr(8'hf7, c);
        `CHK("data reset", 8'h00, c)
        `CHK("owner", 1'b0, port_enable_o)
        `CHK("drivers", 3'b000, oes)
        i_sps_partner.ss_n_o = 1'b1;
    endtask
    task automatic t_master(input logic [1:0] m);
        logic [7:0] c, tx, sl;
        tx = 8'ha5 ^ {6'h00, m};
        sl = 8'h3c ^ {m, 6'h00};
        clock_idle_polarity = m[1];
        clock_phase_select = m[0];
        wr(8'hf8, {4'h3, m, m});
        repeat (4) @(negedge clk_sys_i);
        `CHK("idle level", clock_idle_polarity, sclk_o)
        `CHK("drivers", 3'b110, oes)
        `CHK("owner", 1'b1, port_enable_o)
        i_sps_partner.slv_load(sl);
        slv_on = 1'b1;
        tog = 0;
        wr(8'hf7, tx);
        wait_done(c);
        slv_on = 1'b0;
        `CHK("edges", 16, tog)
        `CHK("span", 15 * (8 << m), t1 - t0)
        `CHK("slave saw", tx, i_sps_partner.srx)
        rdr(8'hf7, c);
        `CHK("master got", sl, c)
        rdr(8'hf8, c);
        `CHK("done clear", 1'b0, c[7])
    endtask
    task automatic t_collide();
        logic [7:0] c;
        clock_idle_polarity = 1'b0;
        clock_phase_select = 1'b0;
        wr(8'hf8, 8'h30);
        i_sps_partner.slv_load(8'h00);
        slv_on = 1'b1;
        wr(8'hf7, 8'h55);
        wr(8'hf7, 8'haa);
        wait_done(c);
        slv_on = 1'b0;
        `CHK("collision", 1'b1, c[6])
        `CHK("kept", 8'h55, i_sps_partner.srx)
        wr(8'hf8, 8'h30);
        rdr(8'hf8, c);
        `CHK("flags clear", 8'h30, c)
    endtask
    task automatic t_abort();
        logic [7:0] c;
        wr(8'hf8, 8'h33);
        wr(8'hf7, 8'hff);
        repeat (300) @(negedge clk_sys_i);
        wr(8'hf8, 8'h03);
        repeat (4) @(negedge clk_sys_i);
        `CHK("released", 3'b000, oes)
        `CHK("owner", 1'b0, port_enable_o)
        repeat (900) @(negedge clk_sys_i);
        rdr(8'hf8, c);
        `CHK("no flags", 2'b00, c[7:6])
    endtask
    task automatic t_slave(input logic [1:0] m);
        logic [7:0] c, r, tx;
        tx = 8'hc3 ^ {m, 6'h00};
        clock_idle_polarity = m[1];
        clock_phase_select = m[0];
        wr(8'hf8, {4'h2, m, 2'b00});
        rdr(8'hf8, c);
        `CHK("select high", 1'b1, c[0])
        wr(8'hf7, tx);
        repeat (4) @(negedge clk_sys_i);
        `CHK("unselected", 3'b000, oes)
        if (m == 2'b00) begin
            i_sps_partner.mst_xfer(8'hff, 1'b0, r);
            rdr(8'hf8, c);
            `CHK("ignored", 1'b0, c[7])
        end
        i_sps_partner.mst_xfer(8'h5a ^ {6'h00, m}, 1'b1, r);
        repeat (8) @(negedge clk_sys_i);
        rdr(8'hf8, c);
        `CHK("slave done", 1'b1, c[7])
        `CHK("select level", ~m[0], c[0])
        `CHK("slave drive", {2'b00, m[0]}, oes)
        `CHK("master saw", tx, r)
        rdr(8'hf7, c);
        `CHK("slave got", 8'h5a ^ {6'h00, m}, c)
        i_sps_partner.ss_n_o = 1'b1;
        repeat (8) @(negedge clk_sys_i);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        rst_n_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        clock_idle_polarity = 1'b0;
        clock_phase_select = 1'b0;
        slv_on = 1'b0;
        sclk_q = 1'b0;
        mismatches = 0;
        comparisons = 0;
        tog = 0;
        cyc = 0;
        t0 = 0;
        t1 = 0;
        repeat (20) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        t_reset();
        for (int i = 0; i < 4; i++) t_master(2'(i));
        t_collide();
        t_abort();
        for (int i = 0; i < 4; i++) t_slave(2'(i));
        print_verdict();
    end
endmodule
